// [gpio_pin_mux.sv]
// How it works
// - Pins only pull low or release, open drain.
// - Two per-pin registers: function and observe select.
// - Reset: pins 2,3 slave serial, others I/O.
// - I/O mode drives low or releases by software.
// - I/O mode also input or blinking LED.
// - Enabled input change sets sticky pending bit.
// - Observe mode enables the driver automatically.
// - Pins 6,7 and 10,11 carry optical serial lines.
// - Module-absent on 0,8 and 9; tick too.
// - Pins 0-5 and 6-11 carry stamp serial lines.
// - Even pins transmit LED, odd pins receive LED.
// - Pins carry framer interrupt A or B.
// - Time pulse, load/save, pulse input on fixed pins.
`timescale 1ns/1ns
`default_nettype none

module gpio_pin_mux #(
  parameter int unsigned BLINK_TICK_CYCLES = gpio_mux_pkg::BLINK_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  // Pin side: level seen, value driven and driver enable.
  input  wire logic [15:0] gpio_in,
  output logic      [15:0] gpio_out,
  output logic      [15:0] gpio_oe,
  // Primary configuration write, one pin per write.
  input  wire logic        cfg_wr,
  input  wire logic [3:0]  cfg_pin,
  input  wire logic [3:0]  cfg_func,
  input  wire logic        cfg_oe,
  input  wire logic        cfg_drive_low,
  input  wire logic        cfg_led,
  input  wire logic [1:0]  cfg_rate,
  input  wire logic        cfg_irq_en,
  // Second configuration write: observe select.
  input  wire logic        cfg2_wr,
  input  wire logic [3:0]  pin_observe_select,
  // Status: synchronised pin levels and sticky change flags.
  output logic      [15:0] pin_level,
  output logic      [15:0] irq_pending,
  input  wire logic [15:0] irq_clr,
  // Core signals sent out on pins.
  input  wire logic [15:0] obs_bus,
  input  wire logic        slave_sda_drive_low,
  input  wire logic        slave_scl_drive_low,
  input  wire logic [1:0]  opt_sda_drive_low,
  input  wire logic [1:0]  opt_scl_drive_low,
  input  wire logic [1:0]  rx_stamp_frame,
  input  wire logic [1:0]  rx_stamp_serial_clock,
  input  wire logic [1:0]  rx_stamp_data,
  input  wire logic [1:0]  tx_stamp_frame,
  input  wire logic [1:0]  tx_stamp_serial_clock,
  input  wire logic        tx_activity_led,
  input  wire logic        rx_activity_led,
  input  wire logic        framer_irq_a,
  input  wire logic        framer_irq_b,
  input  wire logic [1:0]  time_pulse_out,
  // Pin levels returned to the core.
  output logic             slave_sda_in,
  output logic             slave_scl_in,
  output logic      [1:0]  opt_sda_in,
  output logic      [1:0]  opt_scl_in,
  output logic      [1:0]  tx_stamp_data_in,
  output logic             module_absent_ch0,
  output logic             module_absent_ch1,
  output logic             perf_monitor_tick,
  output logic             time_load_save,
  output logic             time_pulse_in
);

  // Per-pin primary configuration fields.
  gpio_mux_pkg::pin_func_t func_ff [16];
  logic [15:0] oe_ff;        // Output enable in plain I/O mode.
  logic [15:0] drv_low_ff;   // Drive low (or LED lit) in plain I/O mode.
  logic [15:0] led_ff;       // Blink the driven value.
  logic [1:0]  rate_ff [16]; // Blink rate, zero is steady.
  logic [15:0] irq_en_ff;    // Change detect enable.
  // Per-pin observe select.
  logic [3:0]  obs_sel_ff [16];

  // Pin levels after the synchroniser and one cycle earlier.
  logic [15:0] lvl;
  logic [15:0] lvl_prev_ff;
  logic [15:0] pend_ff;
  logic [15:0] oe_out_ff;
  logic [15:0] drive_low;
  logic [15:0] fn_hit [gpio_mux_pkg::NUM_FUNCS];

  // Blink timebase.
  logic [gpio_mux_pkg::BLINK_TICK_W-1:0] tick_cnt_ff;
  logic [gpio_mux_pkg::BLINK_DIV_W-1:0]  blink_div_ff;
  logic [3:0]                            blink_on;

  // External pin levels cross into the clock domain before any logic.
  gpio_sync #(
    .W (gpio_mux_pkg::NUM_PINS)
  ) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (gpio_in),
    .q    (lvl)
  );

  // Configuration writes; the reset state picks the default function.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin
        if (i == gpio_mux_pkg::SLAVE_SDA_RST_PIN) begin
          func_ff[i] <= gpio_mux_pkg::FN_SLAVE_SDA;
        end else if (i == gpio_mux_pkg::SLAVE_SCL_RST_PIN) begin
          func_ff[i] <= gpio_mux_pkg::FN_SLAVE_SCL;
        end else begin
          func_ff[i] <= gpio_mux_pkg::RST_FUNC;
        end
        rate_ff[i] <= gpio_mux_pkg::RST_RATE;
      end
      oe_ff      <= {16{gpio_mux_pkg::RST_OE}};
      drv_low_ff <= {16{gpio_mux_pkg::RST_DRV_LOW}};
      led_ff     <= {16{gpio_mux_pkg::RST_LED}};
      irq_en_ff  <= {16{gpio_mux_pkg::RST_IRQ_EN}};
    end else if (cfg_wr) begin
      // Unknown codes are stored as written and simply leave the pin released.
      func_ff[cfg_pin]    <= gpio_mux_pkg::pin_func_t'(cfg_func);
      rate_ff[cfg_pin]    <= cfg_rate;
      oe_ff[cfg_pin]      <= cfg_oe;
      drv_low_ff[cfg_pin] <= cfg_drive_low;
      led_ff[cfg_pin]     <= cfg_led;
      irq_en_ff[cfg_pin]  <= cfg_irq_en;
    end
  end

  // Second register holds the observe select of each pin.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin
        obs_sel_ff[i] <= gpio_mux_pkg::RST_OBS_SEL;
      end
    end else if (cfg2_wr) begin
      obs_sel_ff[cfg_pin] <= pin_observe_select;
    end
  end

  // Free-running blink timebase; one tick per fastest half period.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff  <= '0;
      blink_div_ff <= '0;
    end else if (tick_cnt_ff ==
                 gpio_mux_pkg::BLINK_TICK_W'(BLINK_TICK_CYCLES - 1)) begin
      tick_cnt_ff  <= '0;
      blink_div_ff <= blink_div_ff + 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // Rate zero is steady; higher rates blink faster.
  assign blink_on = {blink_div_ff[0], blink_div_ff[1], blink_div_ff[2], 1'b1};

  // Function hit table: which pins currently hold each function code.
  always_comb begin
    for (int f = 0; f < gpio_mux_pkg::NUM_FUNCS; f++) begin
      for (int i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin
        fn_hit[f][i] = (func_ff[i] == gpio_mux_pkg::pin_func_t'(f[3:0]));
      end
    end
  end

  // Per-pin output selection; each pin only ever asks to pull low.
  for (genvar i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin : g_pin
    localparam int CH = (i < gpio_mux_pkg::STAMP_CH1_BASE) ? 0 : 1;
    localparam int J  = i % gpio_mux_pkg::STAMP_PER_CH;
    localparam int OCH = (i < 8) ? 0 : 1;
    // Stamp slot order per channel; the last slot is an input, so it reads high.
    logic [5:0] stamp_vec;
    assign stamp_vec = {1'b1, tx_stamp_serial_clock[CH], tx_stamp_frame[CH],
                        rx_stamp_data[CH], rx_stamp_serial_clock[CH],
                        rx_stamp_frame[CH]};

    always_comb begin
      drive_low[i] = 1'b0;
      case (func_ff[i])
        gpio_mux_pkg::FN_IO: begin
          // Input mode keeps the driver off; LED mode gates with the blink.
          drive_low[i] = oe_ff[i] & drv_low_ff[i] &
                         (~led_ff[i] | blink_on[rate_ff[i]]);
        end
        gpio_mux_pkg::FN_OBSERVE: begin
          // No enable bit is consulted here.
          drive_low[i] = ~obs_bus[obs_sel_ff[i]];
        end
        gpio_mux_pkg::FN_SLAVE_SDA: begin
          drive_low[i] = gpio_mux_pkg::SLAVE_SDA_PINS[i] & slave_sda_drive_low;
        end
        gpio_mux_pkg::FN_SLAVE_SCL: begin
          drive_low[i] = gpio_mux_pkg::SLAVE_SCL_PINS[i] & slave_scl_drive_low;
        end
        gpio_mux_pkg::FN_OPT_SDA: begin
          drive_low[i] = (gpio_mux_pkg::OPT_SDA_CH0_PINS[i] |
                          gpio_mux_pkg::OPT_SDA_CH1_PINS[i]) &
                         opt_sda_drive_low[OCH];
        end
        gpio_mux_pkg::FN_OPT_SCL: begin
          drive_low[i] = (gpio_mux_pkg::OPT_SCL_CH0_PINS[i] |
                          gpio_mux_pkg::OPT_SCL_CH1_PINS[i]) &
                         opt_scl_drive_low[OCH];
        end
        gpio_mux_pkg::FN_STAMP: begin
          drive_low[i] = gpio_mux_pkg::STAMP_PINS[i] & ~stamp_vec[J];
        end
        gpio_mux_pkg::FN_ACT_LED: begin
          // A lit LED sinks current, so activity pulls the pin low.
          drive_low[i] = (i % 2 == 0) ? tx_activity_led : rx_activity_led;
        end
        gpio_mux_pkg::FN_FRAMER_IRQ: begin
          drive_low[i] = gpio_mux_pkg::FRAMER_B_PINS[i] ?
                         framer_irq_b : framer_irq_a;
        end
        gpio_mux_pkg::FN_TIME_OUT: begin
          drive_low[i] = (gpio_mux_pkg::TIME_OUT_CH0_PINS[i] & ~time_pulse_out[0]) |
                         (gpio_mux_pkg::TIME_OUT_CH1_PINS[i] & ~time_pulse_out[1]);
        end
        default: begin
          // Input functions and unknown codes leave the pin to the board.
          drive_low[i] = 1'b0;
        end
      endcase
    end
  end

  // Registered pin drivers: value is always low, only the enable moves.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oe_out_ff <= '0;
      gpio_out  <= '0;
    end else begin
      oe_out_ff <= drive_low;
      gpio_out  <= '0;
    end
  end

  assign gpio_oe = oe_out_ff;
  assign pin_level = lvl;

  // Change detect on input pins; a new change beats a clear in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lvl_prev_ff <= '1;
      pend_ff     <= '0;
    end else begin
      lvl_prev_ff <= lvl;
      pend_ff     <= (pend_ff & ~irq_clr) |
                     ((lvl ^ lvl_prev_ff) & fn_hit[gpio_mux_pkg::FN_IO] &
                      ~oe_ff & irq_en_ff);
    end
  end

  assign irq_pending = pend_ff;

  // Returned levels: high unless a selected pin reads low, matching an idle bus.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slave_sda_in      <= 1'b1;
      slave_scl_in      <= 1'b1;
      opt_sda_in        <= 2'h3;
      opt_scl_in        <= 2'h3;
      tx_stamp_data_in  <= 2'h3;
      module_absent_ch0 <= 1'b1;
      module_absent_ch1 <= 1'b1;
      perf_monitor_tick <= 1'b1;
      time_load_save    <= 1'b1;
      time_pulse_in     <= 1'b1;
    end else begin
      slave_sda_in <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_SLAVE_SDA] &
                               gpio_mux_pkg::SLAVE_SDA_PINS));
      slave_scl_in <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_SLAVE_SCL] &
                               gpio_mux_pkg::SLAVE_SCL_PINS));
      opt_sda_in[0] <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_OPT_SDA] &
                                gpio_mux_pkg::OPT_SDA_CH0_PINS));
      opt_sda_in[1] <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_OPT_SDA] &
                                gpio_mux_pkg::OPT_SDA_CH1_PINS));
      opt_scl_in[0] <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_OPT_SCL] &
                                gpio_mux_pkg::OPT_SCL_CH0_PINS));
      opt_scl_in[1] <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_OPT_SCL] &
                                gpio_mux_pkg::OPT_SCL_CH1_PINS));
      tx_stamp_data_in[0] <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_STAMP] &
                                      gpio_mux_pkg::STAMP_IN_CH0_PINS));
      tx_stamp_data_in[1] <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_STAMP] &
                                      gpio_mux_pkg::STAMP_IN_CH1_PINS));
      module_absent_ch0 <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_MOD_ABS] &
                                    gpio_mux_pkg::MOD_ABS_CH0_PINS));
      module_absent_ch1 <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_MOD_ABS] &
                                    gpio_mux_pkg::MOD_ABS_CH1_PINS));
      perf_monitor_tick <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_PM_TICK] &
                                    gpio_mux_pkg::PM_TICK_PINS));
      time_load_save    <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_TIME_LOAD] &
                                    gpio_mux_pkg::TIME_LOAD_PINS));
      time_pulse_in     <= &(lvl | ~(fn_hit[gpio_mux_pkg::FN_TIME_IN] &
                                    gpio_mux_pkg::TIME_IN_PINS));
    end
  end

endmodule

`default_nettype wire

// [gpio_mux_pkg.sv]
// Shared constants for the sixteen-pin open-drain pin multiplexer.
package gpio_mux_pkg;

  // Bank geometry.
  localparam int NUM_PINS  = 16;
  localparam int OBS_W     = 16;  // Internal signals offered to observe mode.
  localparam int OBS_SEL_W = 4;   // Width of the observe select field.
  localparam int RATE_W    = 2;   // Width of the blink rate field.
  localparam int STAMP_PER_CH = 6;  // Stamp pins per channel.
  localparam int STAMP_CH1_BASE = 6;  // First stamp pin of channel 1.

  // Pin function codes held in the primary configuration register.
  typedef enum logic [3:0] {
    FN_IO,
    FN_OBSERVE,
    FN_SLAVE_SDA,
    FN_SLAVE_SCL,
    FN_OPT_SDA,
    FN_OPT_SCL,
    FN_MOD_ABS,
    FN_PM_TICK,
    FN_STAMP,
    FN_ACT_LED,
    FN_FRAMER_IRQ,
    FN_TIME_OUT,
    FN_TIME_LOAD,
    FN_TIME_IN
  } pin_func_t;

  localparam int NUM_FUNCS = 16;  // Size of the per-function hit table.

  // Pins that offer each alternate function, one bit per pin.
  localparam logic [15:0] SLAVE_SDA_PINS    = 16'h0004;
  localparam logic [15:0] SLAVE_SCL_PINS    = 16'h0008;
  localparam logic [15:0] OPT_SDA_CH0_PINS  = 16'h0040;
  localparam logic [15:0] OPT_SCL_CH0_PINS  = 16'h0080;
  localparam logic [15:0] OPT_SDA_CH1_PINS  = 16'h0400;
  localparam logic [15:0] OPT_SCL_CH1_PINS  = 16'h0800;
  localparam logic [15:0] MOD_ABS_CH0_PINS  = 16'h0101;
  localparam logic [15:0] MOD_ABS_CH1_PINS  = 16'h0200;
  localparam logic [15:0] PM_TICK_PINS      = 16'h0301;
  localparam logic [15:0] STAMP_PINS        = 16'h0fff;
  localparam logic [15:0] STAMP_IN_CH0_PINS = 16'h0020;
  localparam logic [15:0] STAMP_IN_CH1_PINS = 16'h0800;
  localparam logic [15:0] FRAMER_B_PINS     = 16'h045d;
  localparam logic [15:0] TIME_OUT_CH0_PINS = 16'h0001;
  localparam logic [15:0] TIME_OUT_CH1_PINS = 16'h0a10;
  localparam logic [15:0] TIME_LOAD_PINS    = 16'h0002;
  localparam logic [15:0] TIME_IN_PINS      = 16'h0020;

  // Values after reset.
  localparam int            SLAVE_SDA_RST_PIN = 2;
  localparam int            SLAVE_SCL_RST_PIN = 3;
  localparam pin_func_t     RST_FUNC     = FN_IO;
  localparam logic          RST_OE       = 1'b0;
  localparam logic          RST_DRV_LOW  = 1'b0;
  localparam logic          RST_LED      = 1'b0;
  localparam logic [1:0]    RST_RATE     = 2'h0;
  localparam logic          RST_IRQ_EN   = 1'b0;
  localparam logic [3:0]    RST_OBS_SEL  = 4'h0;

  // Blink timing: the base tick is the fastest half period.
  localparam int CLK_MHZ         = 250;
  localparam int BLINK_TICK_MS   = 125;
  localparam int BLINK_TICK_CYC  = BLINK_TICK_MS * 1000 * CLK_MHZ;
  localparam int BLINK_TICK_W    = 25;
  localparam int BLINK_DIV_W     = 3;

endpackage

// [gpio_sync.sv]
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for pin levels entering the core clock domain.
module gpio_sync #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // The first stage is read only by the second; pins idle high behind pull-ups.
  logic [W-1:0] meta_ff;

  // Both stages reset high so a released pin does not look like a change.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= '1;
      q       <= '1;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// [board_pins.sv]
`timescale 1ns/1ns
`default_nettype none

// Board side of the bank: pull-up resistors plus parts that may pull a pin low.
module board_pins (
  input  wire logic [15:0] gpio_oe,
  input  wire logic [15:0] gpio_out,
  input  wire logic [15:0] ext_low,
  output logic      [15:0] gpio_in
);
  // Any party pulling low wins; otherwise the resistor lifts the line high.
  // An idle pin therefore never shows a stale value, only the pull-up level.
  assign gpio_in = ~((gpio_oe & ~gpio_out) | ext_low);
endmodule

`default_nettype wire

// [gpio_pin_mux_props.sv]
`timescale 1ns/1ns
`default_nettype none

// Port checker for the pin multiplexer: latencies and polarity at the pins.
module gpio_pin_mux_props (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [15:0] gpio_in,
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_oe,
  input wire logic        cfg_wr,
  input wire logic [3:0]  cfg_pin,
  input wire logic [3:0]  cfg_func,
  input wire logic        cfg_oe,
  input wire logic        cfg_drive_low,
  input wire logic        cfg_led,
  input wire logic [15:0] obs_bus,
  input wire logic [15:0] pin_level,
  input wire logic [15:0] irq_pending,
  input wire logic [15:0] irq_clr,
  input wire logic        time_load_save
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [1:0] up_ff;  // Edges since release; the synchroniser is trusted once flushed.

  // Saturating count of edges after reset release.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end

  // Write steps that start each checked behaviour.
  sequence io_low_wr;
    cfg_wr && cfg_func == 4'h0 && cfg_oe && cfg_drive_low && !cfg_led;
  endsequence
  sequence io_in_wr;
    cfg_wr && cfg_func == 4'h0 && !cfg_oe;
  endsequence
  sequence obs_wr;
    cfg_wr && cfg_func == 4'h1 && obs_bus == 16'h0000;
  endsequence
  sequence load_wr;
    cfg_wr && cfg_func == 4'hc && cfg_pin == 4'h1;
  endsequence

  out_zero_a : assert property (gpio_out == 16'h0000)
    else $error("pin output value not zero");
  io_drive_a : assert property (io_low_wr ##1 !cfg_wr |-> ##1 gpio_oe[$past(cfg_pin, 2)])
    else $error("driven-low pin not pulled low");
  io_release_a : assert property (io_in_wr ##1 !cfg_wr |-> ##1 !gpio_oe[$past(cfg_pin, 2)])
    else $error("input pin not released");
  observe_oe_a : assert property (obs_wr ##1 (!cfg_wr && obs_bus == 16'h0000)
                                  |-> ##1 gpio_oe[$past(cfg_pin, 2)])
    else $error("observe pin driver not enabled");
  irq_cause_a : assert property ((irq_pending & ~$past(irq_pending)
                                  & ~($past(pin_level) ^ $past(pin_level, 2))) == 16'h0000)
    else $error("pending bit set without a level change");
  irq_hold_a : assert property (($past(irq_pending) & ~irq_pending & ~$past(irq_clr)) == 16'h0000)
    else $error("pending bit dropped without clear");
  irq_clear_a : assert property ((irq_pending & $past(irq_clr)
                                  & ~($past(pin_level) ^ $past(pin_level, 2))) == 16'h0000)
    else $error("pending bit survived clear");
  level_sync_a : assert property (up_ff == 2'h3 |-> pin_level == $past(gpio_in, 2))
    else $error("pin level not two edges behind pin");
  time_load_a : assert property (load_wr ##1 (!(cfg_wr && cfg_pin == 4'h1) && $stable(pin_level))[*4]
                                 |-> time_load_save == pin_level[1])
    else $error("load input not following pin 1");
endmodule

bind gpio_pin_mux gpio_pin_mux_props chk_u (.clk, .rstn, .gpio_in, .gpio_out, .gpio_oe, .cfg_wr,
  .cfg_pin, .cfg_func, .cfg_oe, .cfg_drive_low, .cfg_led, .obs_bus, .pin_level, .irq_pending,
  .irq_clr, .time_load_save);

`default_nettype wire

// [tb_multifunction_gpio_pin_mux.sv]
`timescale 1ns/1ns
`default_nettype none

// Self-checking bench: random pin settings plus a sweep of every function code.
module tb_multifunction_gpio_pin_mux;
  localparam int TICK = 4;  // Short blink tick so every rate shows in a few hundred cycles.
  logic        clk;
  logic        rstn;
  logic [15:0] gpio_in;
  logic [15:0] gpio_out;
  logic [15:0] gpio_oe;
  logic [15:0] ext_low;  // Board parts pulling pins low.
  logic        cfg_wr;
  logic [3:0]  cfg_pin;
  logic [3:0]  cfg_func;
  logic        cfg_oe;
  logic        cfg_drive_low;
  logic        cfg_led;
  logic [1:0]  cfg_rate;
  logic        cfg_irq_en;
  logic        cfg2_wr;
  logic [3:0]  obs_sel;
  logic [15:0] pin_level;
  logic [15:0] irq_pending;
  logic [15:0] irq_clr;
  logic [15:0] obs_bus;
  logic        sda_low;
  logic        scl_low;
  logic [1:0]  opt_low;    // Both optical lines share one drive.
  logic [1:0]  stamp_lvl;  // All stamp outputs share one level.
  logic        tx_led;
  logic        rx_led;
  logic        irq_a;
  logic        irq_b;
  logic [1:0]  pulse_out;
  wire  [12:0] ret;        // Returned inputs: stamp, optical, slave, absent, tick, load, pulse.
  int          n_errors;
  int          n_checks;
  int          f;
  int          e;
  int          n;
  logic [15:0] v;
  logic [15:0] iev;
  logic [3:0]  s;
  logic        prev;
  int          rf[9] = '{2, 3, 4, 5, 6, 7, 8, 12, 13};

  gpio_pin_mux #(.BLINK_TICK_CYCLES(TICK)) dut_u (.clk(clk), .rstn(rstn), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .cfg_wr(cfg_wr), .cfg_pin(cfg_pin),
    .cfg_func(cfg_func), .cfg_oe(cfg_oe), .cfg_drive_low(cfg_drive_low), .cfg_led(cfg_led),
    .cfg_rate(cfg_rate), .cfg_irq_en(cfg_irq_en), .cfg2_wr(cfg2_wr),
    .pin_observe_select(obs_sel), .pin_level(pin_level), .irq_pending(irq_pending),
    .irq_clr(irq_clr), .obs_bus(obs_bus), .slave_sda_drive_low(sda_low),
    .slave_scl_drive_low(scl_low), .opt_sda_drive_low(opt_low), .opt_scl_drive_low(opt_low),
    .rx_stamp_frame(stamp_lvl), .rx_stamp_serial_clock(stamp_lvl), .rx_stamp_data(stamp_lvl),
    .tx_stamp_frame(stamp_lvl), .tx_stamp_serial_clock(stamp_lvl), .tx_activity_led(tx_led),
    .rx_activity_led(rx_led), .framer_irq_a(irq_a), .framer_irq_b(irq_b),
    .time_pulse_out(pulse_out), .slave_sda_in(ret[5]), .slave_scl_in(ret[6]),
    .opt_sda_in(ret[8:7]), .opt_scl_in(ret[10:9]), .tx_stamp_data_in(ret[12:11]),
    .module_absent_ch0(ret[3]),
    .module_absent_ch1(ret[4]), .perf_monitor_tick(ret[2]), .time_load_save(ret[1]),
    .time_pulse_in(ret[0]));

  board_pins brd_u (.gpio_oe(gpio_oe), .gpio_out(gpio_out), .ext_low(ext_low), .gpio_in(gpio_in));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Writes one pin's primary settings; the caller lowers the strobe after its last write.
  task automatic cfg(input logic [3:0] p, input logic [3:0] fn, input logic oe, input logic dl,
                     input logic led, input logic [1:0] r, input logic ie);
    cfg_wr        = 1'b1;
    cfg_pin       = p;
    cfg_func      = fn;
    cfg_oe        = oe;
    cfg_drive_low = dl;
    cfg_led       = led;
    cfg_rate      = r;
    cfg_irq_en    = ie;
    @(negedge clk);
  endtask

  // Writes all sixteen pins back to back, then lets three edges land.
  task automatic cfg_all(input int fn, input logic oe, input logic [15:0] dl, input logic [15:0] ie);
    for (int p = 0; p < 16; p++) begin
      cfg(p[3:0], fn[3:0], oe, dl[p], 1'b0, 2'h0, ie[p]);
    end
    cfg_wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // Pins pulled low for a function code when its core sources are asserted; ph 0 asserts tx LED and framer A, ph 1 rx LED and framer B.
  function automatic logic [15:0] oe_mask(input int fn, input int ph);
    case (fn)
      1:       return 16'hffff;
      2:       return 16'h0004;
      3:       return 16'h0008;
      4:       return 16'h0440;
      5:       return 16'h0880;
      8:       return 16'h07df;  // Stamp data inputs stay released.
      9:       return ph ? 16'haaaa : 16'h5555;
      10:      return ph ? 16'h045d : 16'hfba2;
      11:      return 16'h0a11;
      default: return 16'h0000;
    endcase
  endfunction

  // Returned inputs when pin p alone is pulled low under code fn.
  function automatic logic [15:0] exp_ret(input int fn, input int p);
    logic [15:0] b;
    b = 16'h0001 << p;
    return {3'h0, !(fn == 8 && p == 11), !(fn == 8 && p == 5), !(fn == 5 && p == 11),
            !(fn == 5 && p == 7), !(fn == 4 && p == 10), !(fn == 4 && p == 6),
            !(fn == 3 && p == 3), !(fn == 2 && p == 2),
            !(fn == 6 && |(b & 16'h0200)), !(fn == 6 && |(b & 16'h0101)),
            !(fn == 7 && |(b & 16'h0301)), !(fn == 12 && p == 1), !(fn == 13 && p == 5)};
  endfunction

  // Main sequence of tests.
  initial begin
    {n_errors, n_checks} = '0;
    {rstn, cfg_wr, cfg2_wr, cfg_pin, cfg_func, cfg_oe, cfg_drive_low} = '0;
    {cfg_led, cfg_rate, cfg_irq_en, obs_sel, ext_low, irq_clr} = '0;
    {scl_low, opt_low, tx_led, rx_led, irq_a, irq_b} = '0;
    sda_low   = 1'b1;
    obs_bus   = 16'hffff;
    stamp_lvl = 2'h3;
    pulse_out = 2'h3;
    void'($urandom(32'h8d2fa30b));
    repeat (20) @(negedge clk);
    chk("oe_rst", gpio_oe, 16'h0000);
    chk("lvl_rst", pin_level, 16'hffff);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk("sda_def", gpio_oe, 16'h0004);
    sda_low = 1'b0;
    scl_low = 1'b1;
    repeat (3) @(negedge clk);
    chk("scl_def", gpio_oe, 16'h0008);
    scl_low = 1'b0;
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      v = 16'($urandom);
      cfg_all(0, 1'b1, v, 16'h0000);
      @(negedge clk);
      chk("io_oe", gpio_oe, v);
      chk("io_lvl", pin_level, ~v);
    end
    $display("test drive done");
    iev = 16'($urandom);
    cfg_all(0, 1'b0, 16'h0000, iev);
    repeat (3) @(negedge clk);
    irq_clr = 16'hffff;  // Drop flags raised as the driven pins were released.
    @(negedge clk);
    irq_clr = 16'h0000;
    for (int p = 0; p < 16; p++) begin
      ext_low = 16'h0001 << p;
      repeat (5) @(negedge clk);
      chk("irq_set", irq_pending, iev & ext_low);
      irq_clr = ext_low;
      @(negedge clk);
      irq_clr = 16'h0000;
      @(negedge clk);
      chk("irq_clr", irq_pending, 16'h0000);
      ext_low = 16'h0000;
      repeat (5) @(negedge clk);
      irq_clr = 16'hffff;
      @(negedge clk);
      irq_clr = 16'h0000;
    end
    $display("test change done");
    for (int r = 0; r < 4; r++) begin
      cfg(4'h5, 4'h0, 1'b1, 1'b1, 1'b1, r[1:0], 1'b0);
      cfg_wr = 1'b0;
      repeat (4) @(negedge clk);
      n = 0;
      prev = gpio_oe[5];
      for (int c = 0; c < 256; c++) begin
        @(negedge clk);
        n += (gpio_oe[5] && !prev) ? 1 : 0;
        prev = gpio_oe[5];
      end
      e = (r == 0) ? 0 : 256 / (2 * TICK * (1 << (3 - r)));
      chk("blink", {15'h0, (n == e) || (r != 0 && n >= e - 1 && n <= e + 1)}, 16'h0001);
    end
    $display("test blink done");
    for (int k = 0; k < 3; k++) begin
      s = 4'($urandom);
      cfg_all(1, 1'b0, 16'h0000, 16'h0000);
      for (int p = 0; p < 16; p++) begin
        cfg2_wr = 1'b1;
        cfg_pin = p[3:0];
        obs_sel = s;
        @(negedge clk);
      end
      cfg2_wr = 1'b0;
      obs_bus = ~(16'h0001 << s);
      repeat (3) @(negedge clk);
      chk("obs_low", gpio_oe, 16'hffff);
      obs_bus = 16'h0001 << s;
      repeat (3) @(negedge clk);
      chk("obs_rel", gpio_oe, 16'h0000);
    end
    $display("test observe done");
    {sda_low, scl_low, opt_low, stamp_lvl, pulse_out, obs_bus} = {4'hf, 4'h0, 16'h0000};
    for (int ph = 0; ph < 2; ph++) begin
      {tx_led, irq_a, rx_led, irq_b} = ph ? 4'h3 : 4'hc;
      for (f = 0; f < 16; f++) begin
        cfg_all(f, 1'b0, 16'h0000, 16'h0000);
        chk("func_oe", gpio_oe, oe_mask(f, ph));
      end
    end
    $display("test functions done");
    {sda_low, scl_low, opt_low, stamp_lvl} = 6'h03;  // Slave, optical and stamp sources release their pins.
    for (int i = 0; i < 9; i++) begin
      cfg_all(rf[i], 1'b0, 16'h0000, 16'h0000);
      for (int p = 0; p < 16; p++) begin
        ext_low = 16'h0001 << p;
        repeat (5) @(negedge clk);
        chk("ret_in", {3'h0, ret}, exp_ret(rf[i], p));
      end
      ext_low = 16'h0000;
    end
    $display("test inputs done");
    end_sim();
  end

  // Watchdog: the tests take about 3000 cycles.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule

`default_nettype wire
